// file: hw/cdsd_pkg.sv
// Package for the control data-stage descriptor engine
package cdsd_pkg;
	localparam int LEN_W = 17;
	localparam int LEN_LSB = 0;
	localparam int PKT_LSB = 17;
	localparam int PKT_W = 5;
	localparam int INTR_LSB = 22;
	localparam int INTR_W = 10;
	localparam int PHASE_BIT = 0;
	localparam int EVAL_NEXT_BIT = 1;
	localparam int SHORT_NOTIFY_BIT = 2;
	localparam int SNOOP_BIT = 3;
	localparam int LINK_BIT = 4;
	localparam int DONE_NOTIFY_BIT = 5;
	localparam int INLINE_BIT = 6;
	localparam int TYPE_LSB = 10;
	localparam int TYPE_W = 6;
	localparam int DIR_BIT = 16;
	localparam logic [5:0] TYPE_DATA_STAGE = 6'h03;
	localparam logic [4:0] CC_SUCCESS = 5'h01;
	localparam logic [4:0] CC_SHORT = 5'h0d;
	localparam logic [4:0] CC_TRB_ERR = 5'h05;
	localparam logic [3:0] INLINE_MAX = 4'h8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_W0 = 8'h10;
	localparam logic [7:0] A_W1 = 8'h14;
	localparam logic [7:0] A_W2 = 8'h18;
	localparam logic [7:0] A_W3 = 8'h1c;
	localparam logic [7:0] A_XFER = 8'h20;
	localparam logic [7:0] A_EVT = 8'h24;
	localparam logic [7:0] A_EVTLEN = 8'h28;
	localparam logic [7:0] A_DMA_LO = 8'h2c;
	localparam logic [7:0] A_DMA_HI = 8'h30;
	localparam logic [7:0] A_DATA = 8'h34;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DECODE = 3'b001,
		ST_MOVE = 3'b010,
		ST_EVENT = 3'b011,
		ST_DONE = 3'b100
	} cdsd_state_t;
	typedef struct packed {
		logic [4:0] code;
		logic [LEN_W-1:0] residual;
		logic [INTR_W-1:0] intr;
		logic to_status;
		logic eval_next;
		logic chained;
	} cdsd_event_t;
endpackage : cdsd_pkg

// file: hw/cdsd_engine.sv
// Data-stage descriptor engine with AHB-Lite register slave
`timescale 1ns/1ps
module cdsd_engine (
	input wire logic hclk, // Core clock
	input wire logic hresetn, // Async reset, low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response
	input wire logic snoop_cfg_en, // Config enable-no-snoop
	output logic [63:0] dma_addr, // Current buffer byte address
	output logic dma_dir_in, // Stage direction
	output logic dma_no_snoop, // Requester attribute
	output logic [4:0] pkts_left, // Packets remaining
	output logic event_valid, // Event pulse
	output cdsd_pkg::cdsd_event_t event_info // Event contents
);
	logic [31:0] w0_r, w1_r, w2_r, w3_r, w0_nxt, w1_nxt, w2_nxt, w3_nxt;
	logic [16:0] done_r, done_nxt, arrived_r, arrived_nxt;
	logic start_r, start_nxt, short_r, short_nxt, busy_r;
	logic [7:0] data_r, data_nxt;
	logic data_vld_r, data_vld_nxt;
	cdsd_pkg::cdsd_state_t st_r, st_nxt;
	cdsd_pkg::cdsd_event_t ev_r, ev_nxt;
	logic ev_v_r, ev_v_nxt;
	logic [63:0] base_addr;
	logic [16:0] len, resid;
	logic inl, dir_in, ev_short, ev_done, bad;
	logic ap_wr_r, ap_rd_r;
	logic [7:0] ap_a_r;
	logic xfer_go, short_in;
	logic cyc_r, cyc_nxt;

	assign base_addr = {w1_r, w0_r};
	assign len = w2_r[cdsd_pkg::LEN_LSB +: cdsd_pkg::LEN_W];
	assign inl = w3_r[cdsd_pkg::INLINE_BIT];
	assign dir_in = w3_r[cdsd_pkg::DIR_BIT];
	assign resid = len - done_r;
	assign bad = (w3_r[cdsd_pkg::TYPE_LSB +: cdsd_pkg::TYPE_W] != cdsd_pkg::TYPE_DATA_STAGE)
		|| (len == 17'h00000) || (inl && (len > {13'h0000, cdsd_pkg::INLINE_MAX}));
	assign ev_short = short_r && w3_r[cdsd_pkg::SHORT_NOTIFY_BIT];
	assign ev_done = w3_r[cdsd_pkg::DONE_NOTIFY_BIT];
	assign busy_r = (st_r != cdsd_pkg::ST_IDLE) && (st_r != cdsd_pkg::ST_DONE);

	// Any byte offset; no alignment rounding
	assign dma_addr = base_addr + {47'h0, done_r};
	assign dma_dir_in = dir_in;
	assign dma_no_snoop = w3_r[cdsd_pkg::SNOOP_BIT] && snoop_cfg_en && busy_r;
	assign pkts_left = w2_r[cdsd_pkg::PKT_LSB +: cdsd_pkg::PKT_W];
	assign event_valid = ev_v_r;
	assign event_info = ev_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_comb begin
		st_nxt = st_r;
		done_nxt = done_r;
		short_nxt = short_r;
		ev_nxt = ev_r;
		ev_v_nxt = 1'b0;
		data_nxt = data_r;
		data_vld_nxt = data_vld_r;
		case (st_r)
			cdsd_pkg::ST_IDLE, cdsd_pkg::ST_DONE: begin
				// Run only when the descriptor's phase matches the consumer phase
				if (start_r && w3_r[cdsd_pkg::PHASE_BIT] == cyc_r) begin
					st_nxt = cdsd_pkg::ST_DECODE;
				end
			end
			cdsd_pkg::ST_DECODE: begin
				done_nxt = 17'h00000;
				short_nxt = 1'b0;
				st_nxt = bad ? cdsd_pkg::ST_EVENT : cdsd_pkg::ST_MOVE;
			end
			cdsd_pkg::ST_MOVE: begin
				if (inl && !dir_in) begin
					data_nxt = inl_byte(done_r[2:0]);
					data_vld_nxt = 1'b1;
				end
				if (xfer_go) begin
					done_nxt = done_r + 17'h00001;
					data_vld_nxt = 1'b0;
					if (done_r + 17'h00001 == len) begin
						st_nxt = cdsd_pkg::ST_EVENT;
					end
				end
				if (short_in) begin
					short_nxt = 1'b1;
					st_nxt = cdsd_pkg::ST_EVENT;
				end
			end
			cdsd_pkg::ST_EVENT: begin
				ev_nxt.intr = w2_r[cdsd_pkg::INTR_LSB +: cdsd_pkg::INTR_W];
				ev_nxt.residual = resid;
				ev_nxt.to_status = short_r || !w3_r[cdsd_pkg::LINK_BIT];
				ev_nxt.eval_next = w3_r[cdsd_pkg::EVAL_NEXT_BIT];
				ev_nxt.chained = w3_r[cdsd_pkg::LINK_BIT] && !short_r;
				ev_nxt.code = bad ? cdsd_pkg::CC_TRB_ERR :
					(short_r ? cdsd_pkg::CC_SHORT : cdsd_pkg::CC_SUCCESS);
				// One event even when both notify flags apply
				ev_v_nxt = bad || ev_short || ev_done;
				st_nxt = cdsd_pkg::ST_DONE;
			end
			default: st_nxt = cdsd_pkg::ST_IDLE;
		endcase
	end

	function automatic logic [7:0] inl_byte(input logic [2:0] i);
		logic [63:0] p;
		p = {w1_r, w0_r};
		inl_byte = p[{i, 3'b000} +: 8];
	endfunction

	// XFER writes with bit 0 set move bytes; in-stage short flagged by bit 1 of XFER
	assign xfer_go = ap_wr_r && ap_a_r == cdsd_pkg::A_XFER && hwdata[0] && st_r == cdsd_pkg::ST_MOVE;
	assign short_in = ap_wr_r && ap_a_r == cdsd_pkg::A_XFER && hwdata[1] && dir_in
		&& st_r == cdsd_pkg::ST_MOVE && !xfer_go;

	always_comb begin
		w0_nxt = w0_r;
		w1_nxt = w1_r;
		w2_nxt = w2_r;
		w3_nxt = w3_r;
		start_nxt = 1'b0;
		cyc_nxt = cyc_r;
		if (ap_wr_r && !busy_r) begin
			case (ap_a_r)
				cdsd_pkg::A_W0: w0_nxt = hwdata;
				cdsd_pkg::A_W1: w1_nxt = hwdata;
				cdsd_pkg::A_W2: w2_nxt = hwdata;
				// Reserved bits 9:7 and 31:17 dropped
				cdsd_pkg::A_W3: w3_nxt = {15'h0000, hwdata[16:10], 3'h0, hwdata[6:0]};
				cdsd_pkg::A_CTRL: begin
					start_nxt = hwdata[0];
					cyc_nxt = hwdata[1];
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		case (ap_a_r)
			cdsd_pkg::A_STAT: hrdata = {24'h000000, 3'h0, short_r, data_vld_r, st_r};
			cdsd_pkg::A_W0: hrdata = w0_r;
			cdsd_pkg::A_W1: hrdata = w1_r;
			cdsd_pkg::A_W2: hrdata = w2_r;
			cdsd_pkg::A_W3: hrdata = w3_r;
			cdsd_pkg::A_XFER: hrdata = {15'h0000, done_r};
			cdsd_pkg::A_EVT: hrdata = {15'h0000, ev_r.to_status, ev_r.eval_next,
				ev_r.chained, 9'h000, ev_r.code};
			cdsd_pkg::A_EVTLEN: hrdata = {5'h00, ev_r.intr, ev_r.residual};
			cdsd_pkg::A_DMA_LO: hrdata = dma_addr[31:0];
			cdsd_pkg::A_DMA_HI: hrdata = dma_addr[63:32];
			cdsd_pkg::A_DATA: hrdata = {24'h000000, data_r};
			default: hrdata = 32'h00000000;
		endcase
		if (!ap_rd_r) begin
			hrdata = 32'h00000000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r <= 1'b0;
			ap_rd_r <= 1'b0;
			ap_a_r <= 8'h00;
			w0_r <= 32'h00000000;
			w1_r <= 32'h00000000;
			w2_r <= 32'h00000000;
			w3_r <= 32'h00000000;
			start_r <= 1'b0;
			cyc_r <= 1'b0;
			st_r <= cdsd_pkg::ST_IDLE;
			done_r <= 17'h00000;
			short_r <= 1'b0;
			ev_r <= '0;
			ev_v_r <= 1'b0;
			data_r <= 8'h00;
			data_vld_r <= 1'b0;
		end else begin
			ap_wr_r <= hsel && hready && htrans[1] && hwrite;
			ap_rd_r <= hsel && hready && htrans[1] && !hwrite;
			ap_a_r <= haddr[7:0];
			w0_r <= w0_nxt;
			w1_r <= w1_nxt;
			w2_r <= w2_nxt;
			w3_r <= w3_nxt;
			start_r <= start_nxt;
			cyc_r <= cyc_nxt;
			st_r <= st_nxt;
			done_r <= done_nxt;
			short_r <= short_nxt;
			ev_r <= ev_nxt;
			ev_v_r <= ev_v_nxt;
			data_r <= data_nxt;
			data_vld_r <= data_vld_nxt;
		end
	end
endmodule // cdsd_engine

// file: sim/cdsd_checker.sv
// Port assertions for the data-stage descriptor engine
`timescale 1ns/1ps
module cdsd_checker (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Type
	input wire logic hwrite, // Write
	input wire logic hready, // Ready
	input wire logic [31:0] hrdata, // Read data
	input wire logic hreadyout, // Slave ready
	input wire logic hresp, // Response
	input wire logic snoop_cfg_en, // Config
	input wire logic dma_no_snoop, // Attribute
	input wire logic dma_dir_in, // Direction
	input wire logic event_valid, // Event
	input wire cdsd_pkg::cdsd_event_t event_info // Contents
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
	rdata_idle_a: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr[7:0] > 8'h34
		|=> hrdata == 32'h0) else $error("unmapped read not zero");
	event_pulse_a: assert property (event_valid |=> !event_valid [*3]) else $error("event repeated");
	snoop_gate_a: assert property (dma_no_snoop |-> snoop_cfg_en) else $error("no-snoop ungated");
	short_status_a: assert property (event_valid && event_info.code == cdsd_pkg::CC_SHORT
		|-> event_info.to_status && event_info.residual != 0) else $error("short event wrong");
	done_res_a: assert property (event_valid && event_info.code == cdsd_pkg::CC_SUCCESS
		|-> event_info.residual == 0) else $error("success with residual");
	dir_hold_a: assert property (dma_no_snoop && $past(dma_no_snoop) |-> $stable(dma_dir_in))
		else $error("direction changed while busy");
endmodule // cdsd_checker

// file: sim/cdsd_soft_model.sv
// Software side: packs data-stage descriptors as posted to the ring
`timescale 1ns/1ps
module cdsd_soft_model;
	// Reserved bits zero; phase is bit 0 of the flags in the descriptor, and the bench copies it to the control write
	function automatic logic [127:0] post(input logic [63:0] buf_a, input logic [16:0] len,
		input logic [4:0] pk, input logic [9:0] it, input logic [6:0] fl, input logic dir,
		input logic [5:0] typ);
		return {15'h0, dir, typ, 3'h0, fl, it, pk, len, buf_a};
	endfunction
endmodule // cdsd_soft_model

// file: sim/control_data_stage_descriptor_bench.sv
// Self-checking bench for the data-stage descriptor engine
`timescale 1ns/1ps
module control_data_stage_descriptor_bench;
	logic hclk, hresetn, hsel, hwrite, snoop_cfg_en, hreadyout, hresp, event_valid;
	logic dma_dir_in, dma_no_snoop;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [63:0] dma_addr;
	logic [4:0] pkts_left;
	wire logic hready;
	cdsd_pkg::cdsd_event_t event_info, e;
	cdsd_pkg::cdsd_event_t exp_q[$];
	int mismatches, compares, seed;
	assign hready = hreadyout;
	cdsd_engine i_dut (
		.hclk(hclk), // Clock
		.hresetn(hresetn), // Reset
		.hsel(hsel), // Select
		.haddr(haddr), // Address
		.htrans(htrans), // Type
		.hwrite(hwrite), // Write
		.hsize(hsize), // Size
		.hwdata(hwdata), // Write data
		.hready(hready), // Ready
		.hrdata(hrdata), // Read data
		.hreadyout(hreadyout), // Slave ready
		.hresp(hresp), // Response
		.snoop_cfg_en(snoop_cfg_en), // Config
		.dma_addr(dma_addr), // Address out
		.dma_dir_in(dma_dir_in), // Direction
		.dma_no_snoop(dma_no_snoop), // Attribute
		.pkts_left(pkts_left), // Packets
		.event_valid(event_valid), // Event
		.event_info(event_info) // Contents
	);
	cdsd_soft_model i_soft ();
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] x, input logic [63:0] s);
		compares++;
		if (x !== s) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, x, s);
		end
	endtask
	task automatic edge_wait;
		int i;
		i = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && i < 50) begin
			@(posedge hclk);
			i++;
		end
		if (i == 50) begin
			mismatches++;
			stop_test();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		edge_wait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_wait();
		r = hrdata;
	endtask
	task automatic run(input string nm, input logic [127:0] d, input int n, input logic sh,
		input logic ev, input cdsd_pkg::cdsd_event_t x);
		logic [31:0] r;
		for (int k = 0; k < 4; k++) bus(1'b1, cdsd_pkg::A_W0 + 8'(4 * k), d[32 * k +: 32], r);
		if (ev)
			exp_q.push_back(x);
		bus(1'b1, cdsd_pkg::A_CTRL, {30'h0, d[96], 1'b1}, r);
		@(posedge hclk);
		@(negedge hclk);
		chk("no_snoop", d[99] & snoop_cfg_en, dma_no_snoop);
		chk("dir_in", d[112], dma_dir_in);
		chk("pkts_left", d[85:81], pkts_left);
		@(posedge hclk);
		for (int i = 0; i < n; i++) begin
			if (d[102]) begin
				bus(1'b0, cdsd_pkg::A_DATA, 32'h0, r);
				chk("inline_byte", d[8 * i +: 8], r[7:0]);
			end
			bus(1'b1, cdsd_pkg::A_XFER, 32'h1, r);
		end
		if (sh)
			bus(1'b1, cdsd_pkg::A_XFER, 32'h2, r);
		r = 32'hffffffff;
		for (int i = 0; i < 30 && r[2:0] !== cdsd_pkg::ST_DONE; i++) bus(1'b0, cdsd_pkg::A_STAT, 32'h0, r);
		chk("state", cdsd_pkg::ST_DONE, r[2:0]);
		chk("short", sh, r[4]);
		if (n > 0)
			chk("dma_addr", d[63:0] + 64'(n), dma_addr);
		@(posedge hclk);
		chk("events_left", 0, exp_q.size());
		$display("%s done", nm);
	endtask
	always @(posedge hclk) begin
		if (event_valid === 1'b1) begin
			e = '1;
			if (exp_q.size() > 0)
				e = exp_q.pop_front();
			chk("event", e, event_info);
		end
	end
	initial begin
		logic [31:0] r;
		logic [63:0] b;
		logic [9:0] it;
		logic [4:0] pk;
		seed = 18055;
		{hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		snoop_cfg_en = 1'b1;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		b = {$random(seed), $random(seed)} | 64'h1;
		it = 10'($random(seed));
		pk = 5'($random(seed));
		run("out chained", i_soft.post(b, 17'h3, pk, it, 7'h3b, 1'b0, cdsd_pkg::TYPE_DATA_STAGE),
			3, 1'b0, 1'b1, {cdsd_pkg::CC_SUCCESS, 17'h0, it, 3'b011});
		snoop_cfg_en <= 1'b0;
		run("in short", i_soft.post(b, 17'h5, pk, it, 7'h2c, 1'b1, cdsd_pkg::TYPE_DATA_STAGE),
			2, 1'b1, 1'b1, {cdsd_pkg::CC_SHORT, 17'h3, it, 3'b100});
		run("quiet short", i_soft.post(b, 17'h4, pk, it, 7'h01, 1'b1, cdsd_pkg::TYPE_DATA_STAGE),
			1, 1'b1, 1'b0, '0);
		run("inline", i_soft.post(b, 17'h8, pk, it, 7'h60, 1'b0, cdsd_pkg::TYPE_DATA_STAGE),
			8, 1'b0, 1'b1, {cdsd_pkg::CC_SUCCESS, 17'h0, it, 3'b100});
		for (int k = 0; k < 3; k++) run("bad", i_soft.post(b, k == 1 ? 17'h0 : (k == 2 ? 17'h9 : 17'h2),
			pk, it, k == 2 ? 7'h40 : 7'h00, 1'b0, k == 0 ? 6'h04 : cdsd_pkg::TYPE_DATA_STAGE),
			0, 1'b0, 1'b1, {cdsd_pkg::CC_TRB_ERR, k == 1 ? 17'h0 : (k == 2 ? 17'h9 : 17'h2), it,
			3'b100});
		bus(1'b1, 8'h3c, 32'h5a5a5a5a, r);
		bus(1'b0, 8'h3c, 32'h0, r);
		chk("unmapped", 32'h0, r);
		stop_test();
	end
endmodule // control_data_stage_descriptor_bench
bind cdsd_engine cdsd_checker i_chk (
	.hclk(hclk), // Clock
	.hresetn(hresetn), // Reset
	.hsel(hsel), // Select
	.haddr(haddr), // Address
	.htrans(htrans), // Type
	.hwrite(hwrite), // Write
	.hready(hready), // Ready
	.hrdata(hrdata), // Read data
	.hreadyout(hreadyout), // Slave ready
	.hresp(hresp), // Response
	.snoop_cfg_en(snoop_cfg_en), // Config
	.dma_no_snoop(dma_no_snoop), // Attribute
	.dma_dir_in(dma_dir_in), // Direction
	.event_valid(event_valid), // Event
	.event_info(event_info) // Contents
);
